// *** verilog/pep_pkg.sv ***
/*
  Constants for the paged register bank of the serial-bus physical layer:
  register indices, field positions, reset values and speed codes.
  Assumes a 32-bit Wishbone slave where register index n sits at byte address 4*n.
*/
package pep_pkg;
  localparam int          IDX_W           = 4;
  // Base registers.
  localparam logic [3:0]  IDX_PWR_CLASS   = 4'h4;
  localparam logic [3:0]  IDX_REQ_STATUS  = 4'h6;
  localparam logic [3:0]  IDX_PAGE_SEL    = 4'h7;
  // Identification page.
  localparam logic [3:0]  IDX_COMPLIANCE  = 4'h8;
  localparam logic [3:0]  IDX_ID_RSVD     = 4'h9;
  localparam logic [3:0]  IDX_OUI_HIGH    = 4'ha;
  localparam logic [3:0]  IDX_OUI_MID     = 4'hb;
  localparam logic [3:0]  IDX_OUI_LOW     = 4'hc;
  localparam logic [3:0]  IDX_PART_HIGH   = 4'hd;
  localparam logic [3:0]  IDX_PART_MID    = 4'he;
  localparam logic [3:0]  IDX_PART_LOW    = 4'hf;
  // Vendor-dependent page.
  localparam logic [3:0]  IDX_PKT_SPEED   = 4'h8;
  // Page selector values.
  localparam logic [2:0]  PAGE_IDENT      = 3'h1;
  localparam logic [2:0]  PAGE_VENDOR     = 3'h7;
  // Field positions within the low data byte.
  localparam int          PAGE_LSB        = 5;
  localparam int          PWR_LSB         = 0;
  localparam int          NPA_BIT         = 7;
  localparam int          LSPD_LSB        = 0;
  localparam int          FAIR_BIT        = 0;
  localparam int          PRIO_BIT        = 1;
  // Reset and fixed values.
  localparam logic [7:0]  COMPLIANCE_VAL  = 8'h01;
  localparam logic [2:0]  PAGE_RST        = 3'h0;
  localparam logic        NPA_RST         = 1'b0;
  localparam logic [1:0]  SPD_S100        = 2'h0;
  localparam logic [1:0]  SPD_S200        = 2'h1;
  localparam logic [1:0]  SPD_S400        = 2'h2;
  localparam logic [1:0]  LSPD_RST        = SPD_S400;
  localparam logic [15:0] ACK_PKT_BITS    = 16'h0008;
  // Power class codes.
  localparam logic [2:0]  PWR_NONE        = 3'h0;
  localparam logic [2:0]  PWR_SELF_45W    = 3'h3;
  localparam logic [2:0]  PWR_BUS_PHY     = 3'h4;
  localparam logic [2:0]  PWR_BUS_LINK_7W = 3'h7;
endpackage : pep_pkg

// *** verilog/pep_regs.sv ***
/*
  Paged register bank of the physical layer: identification page, vendor-dependent
  control page, power class and arbitration request holding, behind a classic
  Wishbone slave with 32-bit data.
  Assumes all inputs are synchronous to clk_i and packet/request events are one-cycle pulses.
*/
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Index 8 of the identification page reads the fixed compliance level 01h.
// - The 24-bit maker identifier reads MSB first from indices 0xa, 0xb and 0xc of the identification page.
// - The 24-bit part identifier reads MSB first from indices 0xd, 0xe and 0xf of the identification page.
// - Writing 7 to the page selector maps the vendor-dependent page into indices 8 to 15.
// - With the hold bit set only a received packet longer than 8 bits clears pending fair and priority requests.
// - With the hold bit clear any received packet that is not exactly 8 bits clears the pending requests.
// - The null-packet hold bit is read/write, 0 after hardware reset and untouched by bus reset.
// - The attached-link speed code is a 2-bit read/write field: 00 S100, 01 S200, 10 S400, 11 illegal.
// - The link speed code is copied into the speed bits of every transmitted self-ID packet.
// - The speed signalled to peer devices during self-ID is always S400.
// - The link speed code is 10b after hardware reset and untouched by bus reset.
// - Hardware reset loads the power class from the three strap inputs for self-ID bits 21 to 23.
// - A write to the power class field replaces the strap value in later self-ID packets.
// - Power class codes run from 000 no need, through self-powered and bus-powered grades, to 111.
// - Writing 1 to the page selector maps the identification page into indices 8 to 15.
module pep_regs
  import pep_pkg::*;
#(
  parameter logic [23:0] MAKER_OUI       = 24'h5a_a5_01, // Arbitrary value.
  parameter logic [23:0] PART_IDENTIFIER = 24'h00_c3_3c  // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Physical layer events.
  input  wire logic        bus_reset_i,
  input  wire logic [2:0]  power_class_strap_i,
  input  wire logic        fair_req_i,
  input  wire logic        prio_req_i,
  input  wire logic        rx_pkt_end_i,
  input  wire logic [15:0] rx_pkt_bits_i,
  // Arbitration and self-ID.
  output logic             fair_req_pending_o,
  output logic             prio_req_pending_o,
  output logic [1:0]       self_id_speed_bits_o,
  output logic [1:0]       peer_speed_signal_o,
  output logic [2:0]       self_id_power_class_o
);
  import pep_pkg::*;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [2:0]  page;
    logic [2:0]  pwr;
    logic        null_packet_hold;
    logic [1:0]  link_speed;
    logic        fair;
    logic        prio;
    logic [1:0]  sid_speed;
    logic [1:0]  peer_speed;
  } pep_state_t;

  pep_state_t st;
  pep_state_t next_st;

  logic [IDX_W-1:0] idx;
  logic             req;
  logic             wr_commit;
  logic             pkt_clears;
  logic             taken;

  // Read value of one register index under the current page.
  function automatic logic [7:0] pep_read(input logic [IDX_W-1:0] i, input pep_state_t s);
    logic [7:0] v;
    v = 8'h00;
    if (i == IDX_PWR_CLASS) begin
      v[PWR_LSB +: 3] = s.pwr;
    end else if (i == IDX_PAGE_SEL) begin
      v[PAGE_LSB +: 3] = s.page;
    end else if (i == IDX_REQ_STATUS) begin
      v[FAIR_BIT] = s.fair;
      v[PRIO_BIT] = s.prio;
    end else if (s.page == PAGE_IDENT) begin
      case (i)
        IDX_COMPLIANCE: v = COMPLIANCE_VAL;
        IDX_OUI_HIGH:   v = MAKER_OUI[23:16];
        IDX_OUI_MID:    v = MAKER_OUI[15:8];
        IDX_OUI_LOW:    v = MAKER_OUI[7:0];
        IDX_PART_HIGH:  v = PART_IDENTIFIER[23:16];
        IDX_PART_MID:   v = PART_IDENTIFIER[15:8];
        IDX_PART_LOW:   v = PART_IDENTIFIER[7:0];
        default:        v = 8'h00;
      endcase
    end else if (s.page == PAGE_VENDOR && i == IDX_PKT_SPEED) begin
      v[NPA_BIT] = s.null_packet_hold;
      v[LSPD_LSB +: 2] = s.link_speed;
    end
    return v;
  endfunction : pep_read

  assign idx        = adr_i[5:2];
  assign req        = cyc_i && stb_i;
  assign taken      = req && !st.ack;
  assign wr_commit  = req && st.ack && we_i && sel_i[0];
  // Exactly 8 bits is an ack packet; the hold bit also spares null and short packets.
  assign pkt_clears = rx_pkt_end_i &&
                      (st.null_packet_hold ? (rx_pkt_bits_i > ACK_PKT_BITS)
                                           : (rx_pkt_bits_i != ACK_PKT_BITS));

  always_comb begin
    next_st = st;
    next_st.ack = req && !st.ack;
    if (req && !st.ack) begin
      next_st.dat = {24'h000000, pep_read(idx, st)};
    end
    // Writes land on the edge at which the master sees ack.
    if (wr_commit) begin
      if (idx == IDX_PAGE_SEL) begin
        next_st.page = dat_i[PAGE_LSB +: 3];
      end
      if (idx == IDX_PWR_CLASS) begin
        next_st.pwr = dat_i[PWR_LSB +: 3];
      end
      if (st.page == PAGE_VENDOR && idx == IDX_PKT_SPEED) begin
        next_st.null_packet_hold = dat_i[NPA_BIT];
        next_st.link_speed = dat_i[LSPD_LSB +: 2];
      end
    end
    // A request arriving with a clearing packet stays pending.
    if (pkt_clears) begin
      next_st.fair = 1'b0;
      next_st.prio = 1'b0;
    end
    if (fair_req_i) begin
      next_st.fair = 1'b1;
    end
    if (prio_req_i) begin
      next_st.prio = 1'b1;
    end
    next_st.sid_speed  = next_st.link_speed;
    next_st.peer_speed = SPD_S400;
    // Bus reset leaves the hold bit, link speed and power class alone.
    if (rst_i) begin
      next_st                  = '0;
      next_st.page             = PAGE_RST;
      next_st.pwr              = power_class_strap_i;
      next_st.null_packet_hold = NPA_RST;
      next_st.link_speed       = LSPD_RST;
      next_st.sid_speed        = LSPD_RST;
      next_st.peer_speed       = SPD_S400;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign dat_o                 = st.dat;
  assign ack_o                 = st.ack;
  assign fair_req_pending_o    = st.fair;
  assign prio_req_pending_o    = st.prio;
  assign self_id_speed_bits_o  = st.sid_speed;
  assign peer_speed_signal_o   = st.peer_speed;
  assign self_id_power_class_o = st.pwr;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_compliance_read: assert property (
    (req && !ack_o && !we_i && idx == IDX_COMPLIANCE && st.page == PAGE_IDENT)
      |=> (ack_o && dat_o == {24'h000000, COMPLIANCE_VAL}))
    else $error("compliance level read wrong");

  a_maker_high_read: assert property (
    (req && !ack_o && idx == IDX_OUI_HIGH && st.page == PAGE_IDENT)
      |=> (dat_o[7:0] == MAKER_OUI[23:16]))
    else $error("maker identifier high byte wrong");

  a_part_high_read: assert property (
    (req && !ack_o && idx == IDX_PART_HIGH && st.page == PAGE_IDENT)
      |=> (dat_o[7:0] == PART_IDENTIFIER[23:16]))
    else $error("part identifier high byte wrong");

  a_page_select_write: assert property (
    (wr_commit && idx == IDX_PAGE_SEL) |=> (st.page == $past(dat_i[PAGE_LSB +: 3])))
    else $error("page selector not written");

  a_hold_keeps_req: assert property (
    (st.null_packet_hold && rx_pkt_end_i && rx_pkt_bits_i <= ACK_PKT_BITS && st.fair)
      |=> fair_req_pending_o)
    else $error("held request cleared by short packet");

  a_nohold_clears_req: assert property (
    (!st.null_packet_hold && rx_pkt_end_i && rx_pkt_bits_i != ACK_PKT_BITS && !fair_req_i && !prio_req_i)
      |=> (!fair_req_pending_o && !prio_req_pending_o))
    else $error("request not cleared by non-ack packet");

  a_bus_reset_keeps: assert property (
    (bus_reset_i && !wr_commit) |=> ($stable(st.null_packet_hold) && $stable(st.link_speed)))
    else $error("bus reset changed control bits");

  a_link_speed_write: assert property (
    (wr_commit && st.page == PAGE_VENDOR && idx == IDX_PKT_SPEED)
      |=> (st.link_speed == $past(dat_i[LSPD_LSB +: 2])) ##1 (self_id_speed_bits_o == st.link_speed))
    else $error("link speed write not carried to self-ID");

  a_peer_speed_fixed: assert property (
    peer_speed_signal_o == SPD_S400)
    else $error("peer speed not S400");

  a_pwr_write: assert property (
    (wr_commit && idx == IDX_PWR_CLASS) |=> (self_id_power_class_o == $past(dat_i[PWR_LSB +: 3])))
    else $error("power class write lost");

  a_reserved_zero: assert property (
    (req && !ack_o && idx == IDX_ID_RSVD) |=> (dat_o == 32'h00000000))
    else $error("reserved index not zero");

  a_ack_single: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_maker_mid_read: assert property (
    (taken && idx == IDX_OUI_MID && st.page == PAGE_IDENT) |=> (dat_o[7:0] == MAKER_OUI[15:8]))
    else $error("maker identifier middle byte wrong");

  a_maker_low_read: assert property (
    (taken && idx == IDX_OUI_LOW && st.page == PAGE_IDENT) |=> (dat_o[7:0] == MAKER_OUI[7:0]))
    else $error("maker identifier low byte wrong");

  a_part_mid_read: assert property (
    (taken && idx == IDX_PART_MID && st.page == PAGE_IDENT) |=> (dat_o[7:0] == PART_IDENTIFIER[15:8]))
    else $error("part identifier middle byte wrong");

  a_part_low_read: assert property (
    (taken && idx == IDX_PART_LOW && st.page == PAGE_IDENT) |=> (dat_o[7:0] == PART_IDENTIFIER[7:0]))
    else $error("part identifier low byte wrong");

  a_ident_select: assert property (
    (wr_commit && idx == IDX_PAGE_SEL && dat_i[PAGE_LSB +: 3] == PAGE_IDENT) |=> (st.page == PAGE_IDENT))
    else $error("identification page not selected");

  a_vendor_select: assert property (
    (wr_commit && idx == IDX_PAGE_SEL && dat_i[PAGE_LSB +: 3] == PAGE_VENDOR) |=> (st.page == PAGE_VENDOR))
    else $error("vendor page not selected");

  a_page_readback: assert property (
    (taken && idx == IDX_PAGE_SEL) |=> (dat_o[PAGE_LSB +: 3] == st.page))
    else $error("page selector read wrong");

  a_vendor_hold_read: assert property (
    (taken && idx == IDX_PKT_SPEED && st.page == PAGE_VENDOR) |=> (dat_o[NPA_BIT] == st.null_packet_hold))
    else $error("hold bit read wrong");

  a_vendor_speed_read: assert property (
    (taken && idx == IDX_PKT_SPEED && st.page == PAGE_VENDOR) |=> (dat_o[LSPD_LSB +: 2] == st.link_speed))
    else $error("link speed read wrong");

  a_hold_write: assert property (
    (wr_commit && st.page == PAGE_VENDOR && idx == IDX_PKT_SPEED) |=> (st.null_packet_hold == $past(dat_i[NPA_BIT])))
    else $error("hold bit write lost");

  a_hold_stable: assert property (
    !(wr_commit && st.page == PAGE_VENDOR && idx == IDX_PKT_SPEED) |=> $stable(st.null_packet_hold))
    else $error("hold bit changed without a write");

  a_speed_stable: assert property (
    !(wr_commit && st.page == PAGE_VENDOR && idx == IDX_PKT_SPEED) |=> $stable(st.link_speed))
    else $error("link speed changed without a write");

  a_speed_page_gate: assert property (
    (wr_commit && st.page != PAGE_VENDOR) |=> $stable(st.link_speed))
    else $error("link speed written outside vendor page");

  a_ident_read_only: assert property (
    (wr_commit && st.page == PAGE_IDENT && idx >= IDX_COMPLIANCE)
      |=> ($stable(st.null_packet_hold) && $stable(st.link_speed) && $stable(st.pwr)))
    else $error("identification page write had an effect");

  a_vendor_test_zero: assert property (
    (taken && st.page == PAGE_VENDOR && idx > IDX_PKT_SPEED) |=> (dat_o == 32'h00000000))
    else $error("test-reserved index not zero");

  a_no_page_zero: assert property (
    (taken && idx >= IDX_COMPLIANCE && st.page != PAGE_IDENT && st.page != PAGE_VENDOR) |=> (dat_o == 32'h00000000))
    else $error("unselected page not zero");

  a_unmapped_zero: assert property (
    (taken && (idx < IDX_PWR_CLASS || idx == 4'h5)) |=> (dat_o == 32'h00000000))
    else $error("unmapped index not zero");

  a_upper_zero: assert property (
    dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  a_sid_speed_copy: assert property (
    self_id_speed_bits_o == st.link_speed)
    else $error("self-ID speed bits differ from link speed");

  a_pwr_stable: assert property (
    !(wr_commit && idx == IDX_PWR_CLASS) |=> $stable(self_id_power_class_o))
    else $error("power class changed without a write");

  a_pwr_sel_gate: assert property (
    (req && st.ack && we_i && !sel_i[0]) |=> ($stable(st.pwr) && $stable(st.page)))
    else $error("write without byte enable had an effect");

  a_pwr_readback: assert property (
    (taken && idx == IDX_PWR_CLASS) |=> (dat_o[PWR_LSB +: 3] == self_id_power_class_o))
    else $error("power class read wrong");

  a_status_read: assert property (
    (taken && idx == IDX_REQ_STATUS) |=> (dat_o[FAIR_BIT] == $past(st.fair) && dat_o[PRIO_BIT] == $past(st.prio)))
    else $error("request status read wrong");

  a_fair_set_wins: assert property (
    fair_req_i |=> fair_req_pending_o)
    else $error("fair request not pending");

  a_prio_set_wins: assert property (
    prio_req_i |=> prio_req_pending_o)
    else $error("priority request not pending");

  a_hold_keeps_prio: assert property (
    (st.null_packet_hold && rx_pkt_end_i && rx_pkt_bits_i <= ACK_PKT_BITS && st.prio) |=> prio_req_pending_o)
    else $error("held priority request cleared by short packet");

  a_hold_long_clears: assert property (
    (st.null_packet_hold && rx_pkt_end_i && rx_pkt_bits_i > ACK_PKT_BITS && !fair_req_i && !prio_req_i)
      |=> (!fair_req_pending_o && !prio_req_pending_o))
    else $error("long packet did not clear held requests");

  a_ack_pkt_spares: assert property (
    (!st.null_packet_hold && rx_pkt_end_i && rx_pkt_bits_i == ACK_PKT_BITS && st.prio) |=> prio_req_pending_o)
    else $error("ack packet cleared priority request");

  a_fair_no_source: assert property (
    (!fair_req_pending_o && !fair_req_i) |=> !fair_req_pending_o)
    else $error("fair request set without a source");

  a_prio_no_source: assert property (
    (!prio_req_pending_o && !prio_req_i) |=> !prio_req_pending_o)
    else $error("priority request set without a source");

  a_idle_keeps: assert property (
    (!rx_pkt_end_i && fair_req_pending_o) |=> fair_req_pending_o)
    else $error("fair request dropped without a packet");

  a_ack_follows: assert property (
    taken |=> ack_o)
    else $error("request not acknowledged");

  a_ack_needs_req: assert property (
    ack_o |-> $past(req))
    else $error("ack without a request");

  a_dat_holds: assert property (
    !taken |=> $stable(dat_o))
    else $error("read data changed without a request");

  c_ident_read:   cover property (req && !ack_o && st.page == PAGE_IDENT && idx == IDX_PART_LOW);
  c_vendor_write: cover property (wr_commit && st.page == PAGE_VENDOR && idx == IDX_PKT_SPEED);
  c_hold_spare:   cover property (st.null_packet_hold && rx_pkt_end_i && st.prio ##1 st.prio);
  c_set_vs_clear: cover property (pkt_clears && fair_req_i);
  c_bus_reset:    cover property (bus_reset_i && st.null_packet_hold);
endmodule : pep_regs
`default_nettype wire

// *** test/pep_link_model.sv ***
/*
  Link-layer controller model: a classic Wishbone master that reaches the PHY registers.
  Assumes clk_i is the PHY clock and that xfer is entered just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pep_link_model (
  // Clock.
  input  wire logic        clk_i,
  // Slave answer.
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  // Master request.
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [5:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end

  // The request stands until ack is sampled; released write data is inverted so it never looks valid.
  task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= wr;
    adr_o <= {idx, 2'h0};
    sel_o <= 4'h1;
    dat_o <= {24'h0, wd};
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~dat_o;
    @(posedge clk_i);
  endtask : xfer
endmodule : pep_link_model
`default_nettype wire

// *** test/tb_phy_extended_register_pages.sv ***
/*
  Self-checking bench for the paged PHY register bank, driven through the link model.
  Assumes the register bank and the link model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_phy_extended_register_pages;
  import pep_pkg::*;
  localparam logic [23:0] OUI  = 24'h3c_96_5a; // Arbitrary value.
  localparam logic [23:0] PART = 24'h81_7e_24; // Arbitrary value.
  logic        clk_i, rst_i, cyc, stb, we, ack, bus_reset, fair, prio, pkt_end, fair_p, prio_p, hold, p;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd;
  logic [15:0] pkt_bits;
  logic [2:0]  strap, pwr;
  logic [1:0]  spd, peer;
  logic [7:0]  v;
  logic [63:0] id_tbl = {8'h01, 8'h00, OUI, PART};
  int          mismatches = 0, checks_done = 0, seed = 47, cycles = 0;

  pep_regs #(.MAKER_OUI(OUI), .PART_IDENTIFIER(PART)) pep_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .bus_reset_i(bus_reset), .power_class_strap_i(strap),
    .fair_req_i(fair), .prio_req_i(prio), .rx_pkt_end_i(pkt_end), .rx_pkt_bits_i(pkt_bits),
    .fair_req_pending_o(fair_p), .prio_req_pending_o(prio_p), .self_id_speed_bits_o(spd),
    .peer_speed_signal_o(peer), .self_id_power_class_o(pwr));
  pep_link_model pep_link_model_i (
    .clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic conclude();
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
    pep_link_model_i.xfer(wr, idx, wd, rd);
  endtask : acc

  task automatic hw_reset();
    strap <= 3'($random(seed));
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : hw_reset

  function automatic logic clears(input logic h, input logic [15:0] bits);
    return h ? (bits > 16'h0008) : (bits != 16'h0008);
  endfunction : clears

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    {rst_i, bus_reset, fair, prio, pkt_end, pkt_bits, strap} = '0;
    hw_reset();
    chk(pwr, strap);
    chk(spd, 2'h2);
    acc(1'b1, 4'h5, 8'hff);
    acc(1'b0, 4'h5, 8'h00);
    chk(rd, 32'h0);
    acc(1'b1, IDX_PAGE_SEL, {PAGE_IDENT, 5'h0});
    acc(1'b1, 4'h9, 8'hff);
    for (int i = 8; i < 16; i++) begin
      acc(1'b0, 4'(i), 8'h00);
      chk(rd, 32'(id_tbl >> (8 * (15 - i)) & 64'hff));
    end
    acc(1'b1, IDX_PAGE_SEL, {PAGE_VENDOR, 5'h0});
    for (int s = 0; s < 4; s++) begin
      v = {s[0], 5'h0, s[1:0]};
      acc(1'b1, 4'h8, v);
      acc(1'b0, 4'h8, 8'h00);
      chk(rd, {24'h0, v});
      repeat (2) @(posedge clk_i);
      chk(spd, s[1:0]);
      chk(peer, 2'h2);
      acc(1'b0, 4'(9 + s), 8'h00);
      chk(rd, 32'h0);
    end
    bus_reset <= 1'b1;
    @(posedge clk_i);
    bus_reset <= 1'b0;
    acc(1'b0, 4'h8, 8'h00);
    chk(rd, 32'h83);
    for (int i = 0; i < 40; i++) begin
      hold = 1'($random(seed));
      p = 1'($random(seed));
      acc(1'b1, 4'h8, {hold, 7'h02});
      fair <= 1'b1;
      prio <= p;
      @(posedge clk_i);
      {fair, prio} <= 2'b00;
      pkt_end <= 1'b1;
      pkt_bits <= (i % 5 == 4) ? 16'($random(seed)) : 16'(6 + i % 5);
      @(posedge clk_i);
      pkt_end <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(fair_p, !clears(hold, pkt_bits));
      chk(prio_p, p & !clears(hold, pkt_bits));
      if (!clears(hold, pkt_bits)) acc(1'b1, 4'h8, 8'h02);
      pkt_end <= !clears(hold, pkt_bits);
      pkt_bits <= 16'h0010;
      repeat (2) @(posedge clk_i);
      pkt_end <= 1'b0;
    end
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, IDX_PWR_CLASS, 8'(c));
      @(posedge clk_i);
      chk(pwr, c[2:0]);
    end
    hw_reset();
    chk(pwr, strap);
    acc(1'b1, IDX_PAGE_SEL, {PAGE_VENDOR, 5'h0});
    acc(1'b0, 4'h8, 8'h00);
    chk(rd, 32'h02);
    conclude();
  end
endmodule : tb_phy_extended_register_pages
`default_nettype wire
